/* File: core/cpfe_pkg.sv */
// Package for the communication and pin fault event block.
// Holds flag indices, widths, reset values and the restart state encoding.
package cpfe_pkg;

    // =========================================================
    // Flag layout
    localparam int unsigned CPFE_NUM_FLAGS   = 9;
    localparam int unsigned CPFE_SPMI        = 0;
    localparam int unsigned CPFE_SPI_FRAMING = 1;
    localparam int unsigned CPFE_PORT1_CRC   = 2;
    localparam int unsigned CPFE_PORT1_ADDR  = 3;
    localparam int unsigned CPFE_PORT2_CRC   = 4;
    localparam int unsigned CPFE_PORT2_ADDR  = 5;
    localparam int unsigned CPFE_SEQUENCER   = 6;
    localparam int unsigned CPFE_ENABLE_PIN  = 7;
    localparam int unsigned CPFE_IRQ_PIN     = 8;

    // =========================================================
    // Widths and reset values
    localparam int unsigned CPFE_DEST_W      = 2;
    localparam logic        CPFE_FLAG_RST    = 1'b0;
    localparam logic        CPFE_LIVE_RST    = 1'b0;
    localparam logic [1:0]  CPFE_DEST_RST    = 2'h0;

    // =========================================================
    // Recovery sequence, Gray coded along run, shut, restart
    typedef enum logic [1:0] {
        CPFE_RUN     = 2'h0,
        CPFE_SHUT    = 2'h1,
        CPFE_RESTART = 2'h3,
        CPFE_LOCKED  = 2'h2
    } cpfe_state_t;

endpackage

/* File: core/cpfe_flag.sv */
// One sticky write-one-to-clear interrupt flag.
// Assumes set, clear and hold are synchronous to core_clk.
`timescale 1ns/10ps
module cpfe_flag
    import cpfe_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic set,
    input  wire logic clear,
    input  wire logic hold,
    output logic      flag
);

    logic next_flag;

    // =========================================================
    // Set beats clear; a clear is ignored while the cause persists
    always_comb begin
        next_flag = set | (flag & ~(clear & ~hold));
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flag <= CPFE_FLAG_RST;
        end else begin
            flag <= next_flag;
        end
    end

endmodule

/* File: core/cpfe_events.sv */
// Fault event logic for serial link errors, sequencer errors and pin readback.
// Assumes all inputs synchronous to core_clk; error inputs are one-cycle pulses.
`timescale 1ns/10ps
module cpfe_events
    import cpfe_pkg::*;
#(
    parameter int unsigned DEST_W = CPFE_DEST_W
)
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              spmi_err,
    input  wire logic              spi_framing_err,
    input  wire logic              port1_crc_err,
    input  wire logic              port1_addr_err,
    input  wire logic              port2_crc_err,
    input  wire logic              port2_addr_err,
    input  wire logic              sequencer_err,
    input  wire logic              enable_drive_cmd,
    input  wire logic              enable_drive_pin_i,
    input  wire logic              irq_out_n_i,
    input  wire logic [8:0]        flag_clear_write,
    input  wire logic              spmi_fault_mask,
    input  wire logic              spi_framing_fault_mask,
    input  wire logic              port1_crc_fault_mask,
    input  wire logic              port1_addr_fault_mask,
    input  wire logic              port2_crc_fault_mask,
    input  wire logic              port2_addr_fault_mask,
    input  wire logic              enable_pin_mismatch_mask,
    input  wire logic              irq_pin_mismatch_mask,
    input  wire logic [DEST_W-1:0] restart_target_state,
    input  wire logic              shutdown_done,
    input  wire logic              tsd_ord_raw,
    input  wire logic              tsd_imm_raw,
    input  wire logic              thermal_recovered,
    output logic                   spmi_fault_flag,
    output logic                   spi_framing_fault_flag,
    output logic                   port1_crc_fault_flag,
    output logic                   port1_addr_fault_flag,
    output logic                   port2_crc_fault_flag,
    output logic                   port2_addr_fault_flag,
    output logic                   sequencer_fault_flag,
    output logic                   enable_pin_mismatch_flag,
    output logic                   irq_pin_mismatch_flag,
    output logic                   enable_pin_mismatch_live,
    output logic                   irq_pin_mismatch_live,
    output logic                   moderate_fault_trigger,
    output logic                   severe_fault_trigger,
    output logic                   shutdown_active,
    output logic                   pulldown_en,
    output logic                   restart_req,
    output logic [DEST_W-1:0]      restart_dest,
    output logic                   restart_locked,
    output logic                   tsd_ord_visible,
    output logic                   tsd_imm_visible,
    output logic                   irq_out_n_o,
    output logic                   irq_out_n_oe
);

    logic [CPFE_NUM_FLAGS-1:0] flags;
    logic [CPFE_NUM_FLAGS-1:0] set_vec;
    logic [CPFE_NUM_FLAGS-1:0] hold_vec;
    logic [CPFE_NUM_FLAGS-1:0] mask_vec;
    logic                      en_mismatch;
    logic                      irq_mismatch;
    logic                      irq_drive;
    logic                      next_en_live;
    logic                      next_irq_live;
    logic                      next_irq_drive;
    logic                      next_moderate;
    logic                      next_severe;
    cpfe_state_t               state;
    cpfe_state_t               next_state;
    logic                      next_pulldown;
    logic [DEST_W-1:0]         next_dest;

    // =========================================================
    // Event sources
    always_comb begin
        en_mismatch  = enable_drive_pin_i != enable_drive_cmd;
        irq_mismatch = irq_drive & irq_out_n_i;
        set_vec = '0;
        set_vec[CPFE_SPMI]        = spmi_err;
        set_vec[CPFE_SPI_FRAMING] = spi_framing_err;
        set_vec[CPFE_PORT1_CRC]   = port1_crc_err;
        set_vec[CPFE_PORT1_ADDR]  = port1_addr_err;
        set_vec[CPFE_PORT2_CRC]   = port2_crc_err;
        set_vec[CPFE_PORT2_ADDR]  = port2_addr_err;
        set_vec[CPFE_SEQUENCER]   = sequencer_err;
        set_vec[CPFE_ENABLE_PIN]  = enable_pin_mismatch_live;
        set_vec[CPFE_IRQ_PIN]     = irq_pin_mismatch_live;
        hold_vec = '0;
        hold_vec[CPFE_ENABLE_PIN] = enable_pin_mismatch_live;
        hold_vec[CPFE_IRQ_PIN]    = irq_pin_mismatch_live;
        mask_vec = '0;
        mask_vec[CPFE_SPMI]        = spmi_fault_mask;
        mask_vec[CPFE_SPI_FRAMING] = spi_framing_fault_mask;
        mask_vec[CPFE_PORT1_CRC]   = port1_crc_fault_mask;
        mask_vec[CPFE_PORT1_ADDR]  = port1_addr_fault_mask;
        mask_vec[CPFE_PORT2_CRC]   = port2_crc_fault_mask;
        mask_vec[CPFE_PORT2_ADDR]  = port2_addr_fault_mask;
        mask_vec[CPFE_ENABLE_PIN]  = enable_pin_mismatch_mask;
        mask_vec[CPFE_IRQ_PIN]     = irq_pin_mismatch_mask;
    end

    // =========================================================
    // Sticky flags, cleared only by a host write of one
    genvar gi;
    generate
        for (gi = 0; gi < CPFE_NUM_FLAGS; gi++) begin : g_flag
            cpfe_flag u_flag (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .set      (set_vec[gi]),
                .clear    (flag_clear_write[gi]),
                .hold     (hold_vec[gi]),
                .flag     (flags[gi])
            );
        end
    endgenerate

    assign spmi_fault_flag          = flags[CPFE_SPMI];
    assign spi_framing_fault_flag   = flags[CPFE_SPI_FRAMING];
    assign port1_crc_fault_flag     = flags[CPFE_PORT1_CRC];
    assign port1_addr_fault_flag    = flags[CPFE_PORT1_ADDR];
    assign port2_crc_fault_flag     = flags[CPFE_PORT2_CRC];
    assign port2_addr_fault_flag    = flags[CPFE_PORT2_ADDR];
    assign sequencer_fault_flag     = flags[CPFE_SEQUENCER];
    assign enable_pin_mismatch_flag = flags[CPFE_ENABLE_PIN];
    assign irq_pin_mismatch_flag    = flags[CPFE_IRQ_PIN];

    // =========================================================
    // Live bits, triggers and the irq pin
    always_comb begin
        next_en_live   = en_mismatch;
        next_irq_live  = irq_mismatch;
        // Mask hides the pin only; flags and triggers ignore it
        next_irq_drive = |(flags & ~mask_vec);
        next_moderate  = spmi_err | (irq_mismatch & ~irq_pin_mismatch_live);
        next_severe    = sequencer_err;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            enable_pin_mismatch_live <= CPFE_LIVE_RST;
            irq_pin_mismatch_live    <= CPFE_LIVE_RST;
            irq_drive                <= 1'b0;
            moderate_fault_trigger   <= 1'b0;
            severe_fault_trigger     <= 1'b0;
        end else begin
            enable_pin_mismatch_live <= next_en_live;
            irq_pin_mismatch_live    <= next_irq_live;
            irq_drive                <= next_irq_drive;
            moderate_fault_trigger   <= next_moderate;
            severe_fault_trigger     <= next_severe;
        end
    end

    // Open drain: only ever pulls low
    assign irq_out_n_o  = 1'b0;
    assign irq_out_n_oe = irq_drive;

    // Thermal flags stay hidden until the part has cooled back down
    assign tsd_ord_visible = tsd_ord_raw & thermal_recovered;
    assign tsd_imm_visible = tsd_imm_raw & thermal_recovered;

    // =========================================================
    // Shutdown and automatic restart
    always_comb begin
        next_state    = state;
        next_pulldown = pulldown_en;
        next_dest     = restart_dest;
        case (state)
            CPFE_RUN: begin
                if (moderate_fault_trigger || severe_fault_trigger) begin
                    next_state    = CPFE_SHUT;
                    next_pulldown = severe_fault_trigger;
                    next_dest     = restart_target_state;
                end
            end
            CPFE_SHUT: begin
                if (shutdown_done) begin
                    next_state = CPFE_RESTART;
                end
            end
            CPFE_RESTART: begin
                next_state    = CPFE_RUN;
                next_pulldown = 1'b0;
            end
            CPFE_LOCKED: begin
                next_state = CPFE_LOCKED;
            end
            default: begin
                next_state = CPFE_RUN;
            end
        endcase
        // Only a supply cycle (reset) leaves the lock
        if (sequencer_err && sequencer_fault_flag) begin
            next_state    = CPFE_LOCKED;
            next_pulldown = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state        <= CPFE_RUN;
            pulldown_en  <= 1'b0;
            restart_dest <= CPFE_DEST_RST;
        end else begin
            state        <= next_state;
            pulldown_en  <= next_pulldown;
            restart_dest <= next_dest;
        end
    end

    assign shutdown_active = state != CPFE_RUN;
    assign restart_req     = state == CPFE_RESTART;
    assign restart_locked  = state == CPFE_LOCKED;

    // =========================================================
    // Checks
    property p_spmi_mod;
        @(posedge core_clk) disable iff (!rst_n)
        spmi_err |=> moderate_fault_trigger && spmi_fault_flag;
    endproperty
    a_spmi_mod: assert property (p_spmi_mod) else $error("spmi error lost");

    property p_restart;
        @(posedge core_clk) disable iff (!rst_n)
        (state == CPFE_SHUT && shutdown_done && !(sequencer_err && sequencer_fault_flag))
            |=> restart_req ##1 (state == CPFE_RUN);
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");

    property p_frame_only;
        @(posedge core_clk) disable iff (!rst_n)
        (spi_framing_err && !spmi_err && !sequencer_err && !irq_mismatch)
            |=> spi_framing_fault_flag && !moderate_fault_trigger && !severe_fault_trigger;
    endproperty
    a_frame_only: assert property (p_frame_only) else $error("framing flag wrong");

    property p_clear_w1;
        @(posedge core_clk) disable iff (!rst_n)
        (port1_crc_fault_flag && !flag_clear_write[CPFE_PORT1_CRC] && !port1_crc_err) |=> port1_crc_fault_flag;
    endproperty
    a_clear_w1: assert property (p_clear_w1) else $error("flag cleared without write");

    property p_addr_set;
        @(posedge core_clk) disable iff (!rst_n)
        (port1_addr_err || port2_addr_err) |=> (port1_addr_fault_flag || port2_addr_fault_flag);
    endproperty
    a_addr_set: assert property (p_addr_set) else $error("address flag missing");

    property p_severe;
        @(posedge core_clk) disable iff (!rst_n)
        (sequencer_err && state == CPFE_RUN) |=> severe_fault_trigger ##1 (pulldown_en && shutdown_active);
    endproperty
    a_severe: assert property (p_severe) else $error("severe shutdown missing");

    property p_lock;
        @(posedge core_clk) disable iff (!rst_n)
        (sequencer_err && sequencer_fault_flag) |=> restart_locked [*4];
    endproperty
    a_lock: assert property (p_lock) else $error("lock not held");

    property p_pin_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (irq_pin_mismatch_live && flag_clear_write[CPFE_IRQ_PIN]) |=> irq_pin_mismatch_flag;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin flag cleared early");

    property p_irq_pin;
        @(posedge core_clk) disable iff (!rst_n)
        (sequencer_fault_flag && !sequencer_err && !flag_clear_write[CPFE_SEQUENCER]) |=> ##1 irq_out_n_oe;
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("irq not driven");

    property p_en_live;
        @(posedge core_clk) disable iff (!rst_n)
        en_mismatch |=> enable_pin_mismatch_live ##1 enable_pin_mismatch_flag;
    endproperty
    a_en_live: assert property (p_en_live) else $error("enable mismatch missed");

endmodule

/* File: verif/cpfe_host_model.sv */
// Far side of the fault block: irq wire with pull-up and the enable pin buffer.
// Assumes the design pulls the irq pin low through irq_out_n_oe only.
`timescale 1ns/10ps
module cpfe_host_model (
    input  wire logic irq_out_n_oe,
    input  wire logic irq_out_n_o,
    input  wire logic irq_stuck,
    input  wire logic enable_drive_cmd,
    input  wire logic enable_fault,
    output logic      irq_wire,
    output logic      enable_drive_pin
);
    // =========================================================
    // Wire levels
    // Released line floats up through the pull-up; a stuck line models a short to supply
    assign irq_wire         = (irq_out_n_oe && !irq_stuck) ? irq_out_n_o : 1'b1;
    // A faulty buffer hands back the inverse of the command
    assign enable_drive_pin = enable_drive_cmd ^ enable_fault;
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the communication and pin fault event block.
// Assumes one 250 MHz clock; inputs change on the falling edge.
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    import cpfe_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [6:0] err = '0;
    logic [8:0] clr = '0;
    logic [7:0] mask = '0;
    logic [1:0] dest = 2'h0;
    logic [8:0] fl;
    logic [5:1] model;
    logic       en_cmd = 1'b0, en_fault = 1'b0, irq_stuck = 1'b0, sd_done = 1'b0;
    logic       tord = 1'b0, timm = 1'b0, trec = 1'b0, any_irq;
    logic       en_pin, irq_wire, live_en, live_irq, mod, sev, sd_act, pd, rreq, lock, vis_o, vis_i;
    logic       irq_o, irq_oe;
    logic [1:0] rdest;
    logic [31:0] lfsr = 32'h82323620;
    int         failures = 0, total_checks = 0, cycles = 0;

    cpfe_events i_dut (.core_clk(core_clk), .rst_n(rst_n), .spmi_err(err[0]), .spi_framing_err(err[1]),
        .port1_crc_err(err[2]), .port1_addr_err(err[3]), .port2_crc_err(err[4]), .port2_addr_err(err[5]),
        .sequencer_err(err[6]), .enable_drive_cmd(en_cmd), .enable_drive_pin_i(en_pin),
        .irq_out_n_i(irq_wire), .flag_clear_write(clr), .spmi_fault_mask(mask[0]),
        .spi_framing_fault_mask(mask[1]), .port1_crc_fault_mask(mask[2]), .port1_addr_fault_mask(mask[3]),
        .port2_crc_fault_mask(mask[4]), .port2_addr_fault_mask(mask[5]), .enable_pin_mismatch_mask(mask[6]),
        .irq_pin_mismatch_mask(mask[7]), .restart_target_state(dest), .shutdown_done(sd_done),
        .tsd_ord_raw(tord), .tsd_imm_raw(timm), .thermal_recovered(trec), .spmi_fault_flag(fl[0]),
        .spi_framing_fault_flag(fl[1]), .port1_crc_fault_flag(fl[2]), .port1_addr_fault_flag(fl[3]),
        .port2_crc_fault_flag(fl[4]), .port2_addr_fault_flag(fl[5]), .sequencer_fault_flag(fl[6]),
        .enable_pin_mismatch_flag(fl[7]), .irq_pin_mismatch_flag(fl[8]), .enable_pin_mismatch_live(live_en),
        .irq_pin_mismatch_live(live_irq), .moderate_fault_trigger(mod), .severe_fault_trigger(sev),
        .shutdown_active(sd_act), .pulldown_en(pd), .restart_req(rreq), .restart_dest(rdest),
        .restart_locked(lock), .tsd_ord_visible(vis_o), .tsd_imm_visible(vis_i), .irq_out_n_o(irq_o),
        .irq_out_n_oe(irq_oe));

    cpfe_host_model i_host (.irq_out_n_oe(irq_oe), .irq_out_n_o(irq_o), .irq_stuck(irq_stuck),
        .enable_drive_cmd(en_cmd), .enable_fault(en_fault), .irq_wire(irq_wire), .enable_drive_pin(en_pin));

    // =========================================================
    // Clock, timeout and helpers
    initial begin
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            finish_test();
        end
    end

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    // Expected sticky flags: a same-cycle set beats the clear
    function automatic logic [5:1] exp_flags(input logic [5:1] f, input logic [5:1] s, input logic [5:1] c);
        return s | (f & ~c);
    endfunction

    task automatic tick();
        @(negedge core_clk);
        lfsr = next_rand(lfsr);
    endtask

    task automatic pulse(input int i);
        err[i] = 1'b1;
        tick();
        err = '0;
    endtask

    // Host acknowledge: a single write-one strobe
    task automatic ack(input int i);
        clr[i] = 1'b1;
        tick();
        clr = '0;
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (6) tick();
        rst_n = 1'b1;
    endtask

    task automatic finish_test();
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // =========================================================
    // Scenarios
    initial begin
        do_reset();
        `CHK(fl, 9'h000)
        `CHK(irq_wire, 1'b1)
        // Interrupt-only sources, with set-wins and acknowledge
        for (int i = 1; i <= 5; i++) begin
            mask[i] = lfsr[0];
            pulse(i);
            `CHK(fl[i], 1'b1)
            `CHK({mod, sev}, 2'h0)
            tick();
            `CHK(irq_oe, ~mask[i])
            `CHK(sd_act, 1'b0)
            err[i] = 1'b1;
            clr[i] = 1'b1;
            tick();
            err = '0;
            clr = '0;
            `CHK(fl[i], 1'b1)
            tick();
            ack(i);
            `CHK(fl[i], 1'b0)
            tick();
            `CHK(irq_oe, 1'b0)
            mask = '0;
        end
        // Masked link error still shuts down and restarts to the target
        mask[0] = 1'b1;
        dest = lfsr[1:0];
        pulse(0);
        `CHK({fl[0], mod}, 2'h3)
        tick();
        `CHK({mod, sd_act, irq_oe}, 3'h2)
        `CHK(rdest, dest)
        sd_done = 1'b1;
        tick();
        sd_done = 1'b0;
        `CHK(rreq, 1'b1)
        tick();
        `CHK(sd_act, 1'b0)
        ack(0);
        `CHK(fl[0], 1'b0)
        // Sequencer error ignores masks; a repeat while pending locks restart
        mask = 8'hff;
        pulse(6);
        `CHK({fl[6], sev, mod}, 3'h6)
        tick();
        `CHK({pd, sd_act, irq_oe}, 3'h7)
        sd_done = 1'b1;
        tick();
        sd_done = 1'b0;
        `CHK(rreq, 1'b1)
        repeat (2) tick();
        pulse(6);
        tick();
        `CHK(lock, 1'b1)
        sd_done = 1'b1;
        repeat (2) tick();
        sd_done = 1'b0;
        `CHK({rreq, lock}, 2'h1)
        mask = '0;
        do_reset();
        `CHK(lock, 1'b0)
        // Enable pin readback in both commanded levels
        for (int v = 0; v < 2; v++) begin
            en_cmd = v[0];
            en_fault = 1'b1;
            tick();
            `CHK({live_en, fl[7]}, 2'h2)
            tick();
            `CHK({fl[7], mod, sd_act}, 3'h4)
            ack(7);
            `CHK(fl[7], 1'b1)
            en_fault = 1'b0;
            tick();
            `CHK(live_en, 1'b0)
            ack(7);
            `CHK(fl[7], 1'b0)
        end
        // Irq pin stuck high while driven low
        pulse(4);
        tick();
        `CHK(irq_wire, 1'b0)
        irq_stuck = 1'b1;
        tick();
        `CHK({live_irq, mod}, 2'h3)
        tick();
        `CHK({fl[8], mod, sd_act}, 3'h5)
        ack(8);
        `CHK(fl[8], 1'b1)
        irq_stuck = 1'b0;
        repeat (2) tick();
        `CHK(live_irq, 1'b0)
        ack(8);
        `CHK(fl[8], 1'b0)
        // Thermal flags gated by recovery
        for (int k = 0; k < 8; k++) begin
            {tord, timm, trec} = k[2:0];
            tick();
            `CHK({vis_o, vis_i}, {tord & trec, timm & trec})
        end
        // Random interrupt-only traffic against a flag model
        do_reset();
        model = '0;
        mask[5:1] = lfsr[5:1];
        for (int n = 0; n < 300; n++) begin
            err[5:1] = lfsr[9:5] & lfsr[14:10];
            clr[5:1] = lfsr[20:16];
            any_irq = |(model & ~mask[5:1]);
            model = exp_flags(model, err[5:1], clr[5:1]);
            tick();
            `CHK(fl[5:1], model)
            `CHK(irq_oe, any_irq)
            `CHK({mod, sd_act}, 2'h0)
        end
        finish_test();
    end
endmodule
